/* dmac_chk.sv */
// Concurrent checks on the ports of the DMA channel block
module dmac_chk (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pslverr,
    input wire logic plain_bus_request,
    input wire logic snoop_bus_request,
    input wire logic bus_grant,
    input wire logic dma_owns_bus,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_ready,
    input wire logic [3:0] io_acknowledge
);
    logic [31:0] hold_q;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Shadow of the last word read, for the write check
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            hold_q <= 32'h0000_0000;
        else if (mem_req && !mem_we && mem_ready)
            hold_q <= mem_rdata;
    end
    property p_grant; mem_req |-> bus_grant; endproperty
    a_grant: assert property (p_grant) else $error("bus cycle without grant");
    property p_own; $rose(dma_owns_bus) |-> $past(plain_bus_request || snoop_bus_request); endproperty
    a_own: assert property (p_own) else $error("bus taken without request");
    property p_kind; !(plain_bus_request && snoop_bus_request); endproperty
    a_kind: assert property (p_kind) else $error("both request kinds high");
    property p_ack1; $onehot0(io_acknowledge); endproperty
    a_ack1: assert property (p_ack1) else $error("two acknowledge lines high");
    property p_ackacc; |io_acknowledge |-> mem_req && dma_owns_bus; endproperty
    a_ackacc: assert property (p_ackacc) else $error("acknowledge outside access");
    property p_hold; mem_req && mem_we |-> mem_wdata == hold_q; endproperty
    a_hold: assert property (p_hold) else $error("write data not the held word");
    property p_rw; mem_req && !mem_we && mem_ready |=> mem_req && mem_we; endproperty
    a_rw: assert property (p_rw) else $error("read not followed by write");
    property p_stable; mem_req && !mem_ready |=> mem_req && $stable(mem_addr); endproperty
    a_stable: assert property (p_stable) else $error("access changed before ready");
    property p_release; mem_req && mem_we && mem_ready && |io_acknowledge |=> !dma_owns_bus;
    endproperty
    a_release: assert property (p_release) else $error("bus kept after last unit");
    property p_err; pslverr |-> psel && penable; endproperty
    a_err: assert property (p_err) else $error("slave error outside access");
endmodule

/* dmac_map.svh */
// Register offsets, field positions, reset values and encodings of the DMA channel block
`ifndef DMAC_MAP_SVH
`define DMAC_MAP_SVH

// ****************************************************************
// Address map
// ****************************************************************
`define DMAC_CHAN_SPACE_BIT 7
`define DMAC_CHAN_LSB 5
`define DMAC_CHAN_MSB 6
`define DMAC_OFS_SRC 5'h00
`define DMAC_OFS_DST 5'h04
`define DMAC_OFS_CNT 5'h08
`define DMAC_OFS_MODE 5'h0C
`define DMAC_OFS_CTRL 5'h10
`define DMAC_OFS_STAT 5'h14
`define DMAC_OFS_HOLD 8'h80

// ****************************************************************
// Count-mode register fields
// ****************************************************************
`define DMAC_MODE_SRC_LSB 0
`define DMAC_MODE_SRC_MSB 2
`define DMAC_MODE_DST_LSB 3
`define DMAC_MODE_DST_MSB 5
`define DMAC_MODE_MAX 3'h4

// ****************************************************************
// Channel control register fields
// ****************************************************************
`define DMAC_CTRL_START 0
`define DMAC_CTRL_SDIR_LSB 1
`define DMAC_CTRL_SDIR_MSB 2
`define DMAC_CTRL_DDIR_LSB 3
`define DMAC_CTRL_DDIR_MSB 4
`define DMAC_CTRL_SIZE_LSB 5
`define DMAC_CTRL_SIZE_MSB 6
`define DMAC_CTRL_SNOOP 7
`define DMAC_CTRL_YIELD 8
`define DMAC_CTRL_SRC_IO 9
`define DMAC_CTRL_DST_IO 10
`define DMAC_CTRL_EXT 11
`define DMAC_CTRL_W 12

// ****************************************************************
// Status register fields
// ****************************************************************
`define DMAC_STAT_READY 0
`define DMAC_STAT_DONE 1
`define DMAC_STAT_CFGERR 2
`define DMAC_STAT_ACTIVE 3

// ****************************************************************
// Encodings and reset values
// ****************************************************************
`define DMAC_DIR_FIXED 2'h0
`define DMAC_DIR_INC 2'h1
`define DMAC_DIR_DEC 2'h2
`define DMAC_SIZE_32 2'h0
`define DMAC_SIZE_16 2'h1
`define DMAC_SIZE_8 2'h2
`define DMAC_RST_ADDR 32'h0000_0000
`define DMAC_RST_CNT 24'h00_0000
`define DMAC_RST_MODE 6'h00
`define DMAC_RST_CTRL 12'h000

`endif

/* dmac_mem_model.sv */
// Core arbiter and memory on the transfer side of the DMA block
module dmac_mem_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic plain_bus_request,
    input wire logic snoop_bus_request,
    output logic bus_grant,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic [31:0] mem_rdata,
    output logic mem_ready,
    output logic [31:0] last_wr_addr,
    output logic [31:0] last_wr_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tog_q;
    logic [31:0] rd_q;
    // Slow mode answers every other cycle; idle data is the inverse of the last word
    assign mem_ready = mem_req && (!slow || tog_q);
    assign mem_rdata = (mem_ready && !mem_we) ? {mem_addr[15:0], ~mem_addr[15:0]} : ~rd_q;
    // Grant lags the request by a cycle; NMI stays pending meanwhile
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            bus_grant <= 1'b0;
        else
            bus_grant <= plain_bus_request || snoop_bus_request;
        tog_q <= !tog_q && rst_n;
        if (mem_ready && !mem_we)
            rd_q <= mem_rdata;
        if (mem_ready && mem_we)
        begin
            last_wr_addr <= mem_addr;
            last_wr_data <= mem_wdata;
        end
    end
endmodule

/* dmac_pkg.sv */
// Types shared by the DMA channel block
package dmac_pkg;
    typedef enum logic [3:0] {
        DMAC_IDLE = 4'b0001,
        DMAC_REQ = 4'b0010,
        DMAC_RD = 4'b0100,
        DMAC_WR = 4'b1000
    } dmac_state_e;
    typedef logic [31:0] dmac_word_t;
    typedef logic [23:0] dmac_count_t;
endpackage

/* dmac_step.sv */
// Address stepper: next address from direction, count-start code and unit size
`include "dmac_map.svh"
module dmac_step
    import dmac_pkg::*;
(
    input wire dmac_word_t addr,
    input wire logic [1:0] dir,
    input wire logic [2:0] cmode,
    input wire logic [1:0] size,
    output dmac_word_t next_addr
);
    // Unit size in bytes
    wire dmac_word_t unit_bytes = (size == `DMAC_SIZE_32) ? 32'h0000_0004 :
                                  (size == `DMAC_SIZE_16) ? 32'h0000_0002 : 32'h0000_0001;
    // Count start at bit 4*code; code zero means a plain size-wide step
    wire logic [4:0] shift_amt = {cmode[2:0], 2'b00};
    wire dmac_word_t step = (cmode == 3'h0) ? unit_bytes : (32'h0000_0001 << shift_amt);
    // Fixed keeps the address, which is what an I/O port needs
    assign next_addr = (dir == `DMAC_DIR_INC) ? addr + step :
                       (dir == `DMAC_DIR_DEC) ? addr - step : addr;
endmodule

/* dmac_top.sv */
// Four-channel dual-address DMA engine with APB register slave and bus arbitration
`include "dmac_map.svh"
module dmac_top
    import dmac_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] xfer_req,
    output logic plain_bus_request,
    output logic snoop_bus_request,
    input wire logic bus_grant,
    input wire logic release_req,
    output logic dma_owns_bus,
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    output logic [1:0] mem_size,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_ready,
    output logic [3:0] io_acknowledge
);

    // ****************************************************************
    // Storage
    // ****************************************************************
    dmac_word_t source_address_reg [4];
    dmac_word_t destination_address_reg [4];
    dmac_count_t byte_count_reg [4];
    logic [5:0] count_mode_reg [4];
    logic [`DMAC_CTRL_W-1:0] channel_control_reg [4];
    dmac_word_t holding_word_reg;
    logic [3:0] ready_q;
    logic [3:0] done_q;
    logic [3:0] cfgerr_q;
    logic [1:0] cur_q;
    logic [1:0] cur_d;
    dmac_state_e state_q;
    dmac_state_e state_d;

    // ****************************************************************
    // APB decode
    // ****************************************************************
    // Channel registers sit below 0x80, one 32-byte window per channel
    wire logic in_chan = ~paddr[`DMAC_CHAN_SPACE_BIT];
    wire logic [1:0] wch = paddr[`DMAC_CHAN_MSB:`DMAC_CHAN_LSB];
    wire logic [4:0] wofs = paddr[4:0];
    wire logic sel_src = in_chan & (wofs == `DMAC_OFS_SRC);
    wire logic sel_dst = in_chan & (wofs == `DMAC_OFS_DST);
    wire logic sel_cnt = in_chan & (wofs == `DMAC_OFS_CNT);
    wire logic sel_mode = in_chan & (wofs == `DMAC_OFS_MODE);
    wire logic sel_ctrl = in_chan & (wofs == `DMAC_OFS_CTRL);
    wire logic sel_stat = in_chan & (wofs == `DMAC_OFS_STAT);
    wire logic sel_hold = (paddr == `DMAC_OFS_HOLD);
    wire logic mapped = sel_src | sel_dst | sel_cnt | sel_mode | sel_ctrl | sel_stat |
                        (sel_hold & ~pwrite);
    wire logic acc = psel & penable;
    wire logic wr_ok = acc & pwrite & mapped;

    // Zero wait states; unmapped or a write to the holding word errors
    assign pready = 1'b1;
    assign pslverr = acc & ~mapped;

    // ****************************************************************
    // Start check
    // ****************************************************************
    // A bad setup is refused at start rather than mid-transfer
    wire logic [`DMAC_CTRL_W-1:0] wctrl = pwdata[`DMAC_CTRL_W-1:0];
    wire logic [1:0] w_sdir = wctrl[`DMAC_CTRL_SDIR_MSB:`DMAC_CTRL_SDIR_LSB];
    wire logic [1:0] w_ddir = wctrl[`DMAC_CTRL_DDIR_MSB:`DMAC_CTRL_DDIR_LSB];
    wire logic w_sio = wctrl[`DMAC_CTRL_SRC_IO];
    wire logic w_dio = wctrl[`DMAC_CTRL_DST_IO];
    wire logic [5:0] w_mode = count_mode_reg[wch];
    wire logic start_wr = wr_ok & sel_ctrl & wctrl[`DMAC_CTRL_START];
    wire logic cfg_bad = (w_sio & w_dio) |
                         (w_sio & (w_sdir != `DMAC_DIR_FIXED)) |
                         (w_dio & (w_ddir != `DMAC_DIR_FIXED)) |
                         (w_sdir == 2'h3) | (w_ddir == 2'h3) |
                         (wctrl[`DMAC_CTRL_SIZE_MSB:`DMAC_CTRL_SIZE_LSB] == 2'h3) |
                         (w_mode[`DMAC_MODE_SRC_MSB:`DMAC_MODE_SRC_LSB] > `DMAC_MODE_MAX) |
                         (w_mode[`DMAC_MODE_DST_MSB:`DMAC_MODE_DST_LSB] > `DMAC_MODE_MAX) |
                         ((w_sio | w_dio) & ~wctrl[`DMAC_CTRL_EXT]) |
                         (byte_count_reg[wch] == `DMAC_RST_CNT) | done_q[wch];
    wire logic start_ok = start_wr & ~cfg_bad & ~ready_q[wch];
    wire logic start_bad = start_wr & cfg_bad;

    // ****************************************************************
    // Active channel view
    // ****************************************************************
    wire logic [`DMAC_CTRL_W-1:0] cc = channel_control_reg[cur_q];
    wire logic [1:0] unit_size = cc[`DMAC_CTRL_SIZE_MSB:`DMAC_CTRL_SIZE_LSB];
    wire logic snoop = cc[`DMAC_CTRL_SNOOP];
    wire logic src_io = cc[`DMAC_CTRL_SRC_IO];
    wire logic dst_io = cc[`DMAC_CTRL_DST_IO];
    wire logic mem_mem = ~src_io & ~dst_io;
    wire logic [5:0] cm = count_mode_reg[cur_q];
    wire dmac_count_t remaining_bytes = byte_count_reg[cur_q];
    wire dmac_count_t unit_bytes = (unit_size == `DMAC_SIZE_32) ? 24'h00_0004 :
                                   (unit_size == `DMAC_SIZE_16) ? 24'h00_0002 : 24'h00_0001;
    // A count that is not a multiple of the unit ends at zero, never wraps
    wire dmac_count_t count_next = (remaining_bytes < unit_bytes) ? `DMAC_RST_CNT :
                                   remaining_bytes - unit_bytes;
    wire logic last_unit = (count_next == `DMAC_RST_CNT);
    wire dmac_word_t src_next;
    wire dmac_word_t dst_next;

    // Source and destination steppers for the channel that holds the bus
    dmac_step u_src_step (
        .addr(source_address_reg[cur_q]),
        .dir(cc[`DMAC_CTRL_SDIR_MSB:`DMAC_CTRL_SDIR_LSB]),
        .cmode(cm[`DMAC_MODE_SRC_MSB:`DMAC_MODE_SRC_LSB]),
        .size(unit_size),
        .next_addr(src_next)
    );
    dmac_step u_dst_step (
        .addr(destination_address_reg[cur_q]),
        .dir(cc[`DMAC_CTRL_DDIR_MSB:`DMAC_CTRL_DDIR_LSB]),
        .cmode(cm[`DMAC_MODE_DST_MSB:`DMAC_MODE_DST_LSB]),
        .size(unit_size),
        .next_addr(dst_next)
    );

    // ****************************************************************
    // Request selection
    // ****************************************************************
    // Ready internal channels always request; ready external ones follow their line
    logic [3:0] pend;
    logic [1:0] pick;
    always_comb
    begin
        pick = 2'h0;
        for (int i = 0; i < 4; i++)
        begin
            pend[i] = ready_q[i] & (~channel_control_reg[i][`DMAC_CTRL_EXT] | xfer_req[i]);
        end
        // Fixed priority, channel 0 highest
        for (int i = 3; i >= 0; i--)
        begin
            if (pend[i])
            begin
                pick = 2'(i);
            end
        end
    end

    // ****************************************************************
    // Transfer sequencer
    // ****************************************************************
    wire logic unit_done = (state_q == DMAC_WR) & mem_ready;
    wire logic yield_now = release_req & cc[`DMAC_CTRL_YIELD] & ~snoop;

    always_comb
    begin
        state_d = state_q;
        cur_d = cur_q;
        unique case (state_q)
            DMAC_IDLE:
            begin
                if (|pend)
                begin
                    cur_d = pick;
                    state_d = DMAC_REQ;
                end
            end
            DMAC_REQ:
            begin
                if (bus_grant)
                begin
                    state_d = DMAC_RD;
                end
            end
            DMAC_RD:
            begin
                if (mem_ready)
                begin
                    state_d = DMAC_WR;
                end
            end
            DMAC_WR:
            begin
                if (mem_ready)
                begin
                    // External channels hand back the bus after every unit
                    if (last_unit | yield_now | cc[`DMAC_CTRL_EXT])
                    begin
                        state_d = DMAC_IDLE;
                    end
                    else
                    begin
                        state_d = DMAC_RD;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state_q <= DMAC_IDLE;
            cur_q <= 2'h0;
        end
        else
        begin
            state_q <= state_d;
            cur_q <= cur_d;
        end
    end

    // Read data is parked here until its own write cycle
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            holding_word_reg <= `DMAC_RST_ADDR;
        end
        else if ((state_q == DMAC_RD) && mem_ready)
        begin
            holding_word_reg <= mem_rdata;
        end
    end

    // ****************************************************************
    // Channel registers
    // ****************************************************************
    // The engine update beats a software write to the same channel
    always_ff @(posedge mclk)
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (!rst_n)
            begin
                source_address_reg[i] <= `DMAC_RST_ADDR;
                destination_address_reg[i] <= `DMAC_RST_ADDR;
                byte_count_reg[i] <= `DMAC_RST_CNT;
            end
            else if (unit_done && (cur_q == 2'(i)))
            begin
                source_address_reg[i] <= src_next;
                destination_address_reg[i] <= dst_next;
                byte_count_reg[i] <= count_next;
            end
            else if (wr_ok && (wch == 2'(i)))
            begin
                if (sel_src)
                    source_address_reg[i] <= pwdata;
                if (sel_dst)
                    destination_address_reg[i] <= pwdata;
                if (sel_cnt)
                    byte_count_reg[i] <= pwdata[23:0];
            end
        end
    end

    // Mode and control words; start bit itself is not stored
    always_ff @(posedge mclk)
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (!rst_n)
            begin
                count_mode_reg[i] <= `DMAC_RST_MODE;
                channel_control_reg[i] <= `DMAC_RST_CTRL;
            end
            else if (wr_ok && (wch == 2'(i)) && !ready_q[i])
            begin
                if (sel_mode)
                    count_mode_reg[i] <= pwdata[5:0];
                if (sel_ctrl && !cfg_bad)
                    channel_control_reg[i] <= {wctrl[`DMAC_CTRL_W-1:1], 1'b0};
            end
        end
    end

    // Ready, done and error flags; hardware set wins over a clear
    wire logic [3:0] fin_set = {4{unit_done & last_unit}} & (4'h1 << cur_q);
    wire logic [3:0] start_set = {4{start_ok}} & (4'h1 << wch);
    wire logic [3:0] err_set = {4{start_bad}} & (4'h1 << wch);
    wire logic [3:0] stat_wr = {4{wr_ok & sel_stat}} & (4'h1 << wch);
    wire logic [3:0] clr_done = stat_wr & {4{pwdata[`DMAC_STAT_DONE]}};
    wire logic [3:0] clr_err = stat_wr & {4{pwdata[`DMAC_STAT_CFGERR]}};
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            ready_q <= 4'h0;
            done_q <= 4'h0;
            cfgerr_q <= 4'h0;
        end
        else
        begin
            ready_q <= (ready_q & ~fin_set) | start_set;
            done_q <= (done_q & ~clr_done) | fin_set;
            cfgerr_q <= (cfgerr_q & ~clr_err) | err_set;
        end
    end

    // ****************************************************************
    // Read mux
    // ****************************************************************
    wire logic [31:0] stat_word = {28'h000_0000, (state_q != DMAC_IDLE) && (cur_q == wch),
                                   cfgerr_q[wch], done_q[wch], ready_q[wch]};
    wire logic [31:0] rd_word = sel_src ? source_address_reg[wch] :
                                sel_dst ? destination_address_reg[wch] :
                                sel_cnt ? {8'h00, byte_count_reg[wch]} :
                                sel_mode ? {26'h000_0000, count_mode_reg[wch]} :
                                sel_ctrl ? {20'h0_0000, channel_control_reg[wch]} :
                                sel_stat ? stat_word :
                                sel_hold ? holding_word_reg : 32'h0000_0000;
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata <= rd_word;
    end

    // ****************************************************************
    // Bus side outputs
    // ****************************************************************
    wire logic want_bus = (state_q != DMAC_IDLE);
    assign plain_bus_request = want_bus & ~snoop;
    assign snoop_bus_request = want_bus & snoop;
    // Core keys its NMI hold off this level
    assign dma_owns_bus = (state_q == DMAC_RD) | (state_q == DMAC_WR);
    assign mem_req = dma_owns_bus;
    assign mem_we = (state_q == DMAC_WR);
    assign mem_addr = mem_we ? destination_address_reg[cur_q] : source_address_reg[cur_q];
    assign mem_wdata = holding_word_reg;
    assign mem_size = unit_size;

    // Acknowledge: every I/O access, or the final memory-to-memory unit
    wire logic ack_now = ((state_q == DMAC_RD) & src_io) |
                         ((state_q == DMAC_WR) & (dst_io | (mem_mem & last_unit)));
    assign io_acknowledge = {4{ack_now}} & (4'h1 << cur_q);

endmodule

/* test_dmac_top.sv */
// Self-checking bench for the DMA channel block
`include "dmac_map.svh"
module test_dmac_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] O_SRC = 8'(`DMAC_OFS_SRC);
    localparam logic [7:0] O_DST = 8'(`DMAC_OFS_DST);
    localparam logic [7:0] O_CNT = 8'(`DMAC_OFS_CNT);
    localparam logic [7:0] O_MODE = 8'(`DMAC_OFS_MODE);
    localparam logic [7:0] O_CTRL = 8'(`DMAC_OFS_CTRL);
    localparam logic [7:0] O_ST = 8'(`DMAC_OFS_STAT);
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] xfer_req = 4'h0;
    logic release_req = 1'b0;
    logic slow = 1'b0;
    logic pready, pslverr, plain_bus_request, snoop_bus_request, bus_grant, dma_owns_bus;
    logic mem_req, mem_we, mem_ready, ev;
    logic [1:0] mem_size;
    logic [3:0] io_acknowledge;
    logic [31:0] prdata, mem_addr, mem_wdata, mem_rdata, last_wr_addr, last_wr_data, rv;
    int err_count = 0;
    int samples_checked = 0;
    // Memory-to-memory rows: size, directions, count starts
    logic [1:0] t_sz [3] = '{`DMAC_SIZE_32, `DMAC_SIZE_16, `DMAC_SIZE_8};
    logic [1:0] t_sd [3] = '{`DMAC_DIR_INC, `DMAC_DIR_DEC, `DMAC_DIR_INC};
    logic [1:0] t_dd [3] = '{`DMAC_DIR_INC, `DMAC_DIR_DEC, `DMAC_DIR_INC};
    logic [2:0] t_sm [3] = '{3'h0, 3'h2, 3'h3};
    logic [2:0] t_dm [3] = '{3'h1, 3'h0, 3'h4};

    always #2 mclk = ~mclk;

    dmac_top i_dmac_top (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .xfer_req(xfer_req), .plain_bus_request(plain_bus_request),
        .snoop_bus_request(snoop_bus_request), .bus_grant(bus_grant),
        .release_req(release_req), .dma_owns_bus(dma_owns_bus), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_size(mem_size),
        .mem_rdata(mem_rdata), .mem_ready(mem_ready), .io_acknowledge(io_acknowledge));
    dmac_mem_model i_dmac_mem_model (.mclk(mclk), .rst_n(rst_n), .slow(slow),
        .plain_bus_request(plain_bus_request), .snoop_bus_request(snoop_bus_request),
        .bus_grant(bus_grant), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ready(mem_ready),
        .last_wr_addr(last_wr_addr), .last_wr_data(last_wr_data));

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do
            @(posedge mclk);
        while (pready !== 1'b1);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, rv, exp);
    endtask
    // Status low bits only; the active flag depends on bus timing
    task automatic st(input logic [7:0] b, input logic [31:0] exp, input string nm);
        apb(1'b0, b + O_ST, 32'h0000_0000);
        chk(nm, rv & 32'h0000_0007, exp);
    endtask
    function automatic logic [31:0] nxt(input logic [31:0] a, input logic [1:0] dir,
        input logic [2:0] c, input logic [1:0] sz);
        logic [31:0] s;
        s = (c != 3'h0) ? (32'h1 << (4 * c)) : (32'h4 >> sz);
        return (dir == `DMAC_DIR_INC) ? a + s : (dir == `DMAC_DIR_DEC) ? a - s : a;
    endfunction
    // Two units memory to memory; odd rows use plain request, yield and a slow memory
    task automatic mm_row(input int k);
        logic [31:0] s, d, ls;
        int u;
        s = 32'hA000_1000;
        d = 32'hB000_0000;
        slow <= k[0];
        release_req <= k[0];
        apb(1'b1, O_ST, 32'h0000_0006);
        apb(1'b1, O_SRC, s);
        apb(1'b1, O_DST, d);
        apb(1'b1, O_CNT, 32'h0000_0002 << (2 - t_sz[k]));
        apb(1'b1, O_MODE, {26'h0, t_dm[k], t_sm[k]});
        apb(1'b1, O_CTRL, {23'h0, k[0], ~k[0], t_sz[k], t_dd[k], t_sd[k], 1'b1});
        for (u = 0; u == 0 || (u < 300 && rv[1] !== 1'b1); u++)
            apb(1'b0, O_ST, 32'h0000_0000);
        for (u = 0; u < 2; u++)
        begin
            ls = s;
            chk(u ? "dst addr" : "size", u ? last_wr_addr : mem_size, u ? d : t_sz[k]);
            s = nxt(s, t_sd[k], t_sm[k], t_sz[k]);
            d = nxt(d, t_dd[k], t_dm[k], t_sz[k]);
        end
        chk("dst data", last_wr_data, {ls[15:0], ~ls[15:0]});
        rdchk(O_SRC, s, "src stepped");
        rdchk(O_DST, d, "dst stepped");
        rdchk(O_CNT, 32'h0000_0000, "count spent");
        rdchk(8'h80, {ls[15:0], ~ls[15:0]}, "holding word");
        st(8'h00, 32'h0000_0002, "mem done");
        $display("test mem row %0d done", k);
    endtask

    // Watchdog: the tests need a few hundred cycles
    initial
    begin
        #(20000 * 4);
        err_count++;
        print_verdict();
    end

    initial
    begin
        int n, u;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        rdchk(O_SRC, 32'h0000_0000, "src reset");
        rdchk(O_MODE, 32'h0000_0000, "mode reset");
        apb(1'b1, O_CNT, 32'hFFFF_FFFF);
        rdchk(O_CNT, 32'h00FF_FFFF, "count width");
        apb(1'b1, O_MODE, 32'h0000_0024);
        rdchk(O_MODE, 32'h0000_0024, "mode fields");
        apb(1'b0, 8'h18, 32'h0000_0000);
        chk("unmapped error", ev, 1'b1);
        apb(1'b1, 8'h80, 32'h0000_0001);
        chk("holding read only", ev, 1'b1);
        $display("test registers done");
        for (n = 0; n < 3; n++)
            mm_row(n);
        // I/O source on channel 1, external requests, two units
        apb(1'b1, 8'h20 + O_SRC, 32'h0000_4000);
        apb(1'b1, 8'h20 + O_DST, 32'h0000_8000);
        apb(1'b1, 8'h20 + O_CNT, 32'h0000_0008);
        apb(1'b1, 8'h20 + O_CTRL, 32'h0000_0A09);
        st(8'h20, 32'h0000_0001, "io ready");
        for (u = 0; u < 2; u++)
        begin
            xfer_req[1] <= 1'b1;
            for (n = 0; n < 100 && !(io_acknowledge[1] === 1'b1 && mem_ready); n++)
                @(posedge mclk);
            xfer_req[1] <= 1'b0;
            for (n = 0; n < 100 && dma_owns_bus !== 1'b0; n++)
                @(posedge mclk);
            rdchk(8'h20 + O_CNT, 32'h8 - 4 * (u + 1), "io count");
            st(8'h20, u ? 32'h0000_0002 : 32'h0000_0001, "io status");
        end
        rdchk(8'h20 + O_SRC, 32'h0000_4000, "io src fixed");
        rdchk(8'h20 + O_DST, 32'h0000_8008, "io dst");
        chk("io data", last_wr_data, 32'h4000_BFFF);
        $display("test io done");
        apb(1'b1, 8'h40 + O_CNT, 32'h0000_0004);
        apb(1'b1, 8'h40 + O_CTRL, 32'h0000_0E01);
        st(8'h40, 32'h0000_0004, "two io refused");
        apb(1'b1, 8'h60 + O_CNT, 32'h0000_0004);
        apb(1'b1, 8'h60 + O_MODE, 32'h0000_0005);
        apb(1'b1, 8'h60 + O_CTRL, 32'h0000_0001);
        st(8'h60, 32'h0000_0004, "reserved code refused");
        $display("test refusals done");
        print_verdict();
    end
endmodule

bind dmac_top dmac_chk i_dmac_chk (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pslverr(pslverr), .plain_bus_request(plain_bus_request),
    .snoop_bus_request(snoop_bus_request), .bus_grant(bus_grant),
    .dma_owns_bus(dma_owns_bus), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ready(mem_ready),
    .io_acknowledge(io_acknowledge));
